// [ctpc_pkg.sv]
`default_nettype none
package ctpc_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_BASE       = 8'h36;
    localparam logic [7:0] IDX_CLOCK_PATH = 8'h36;
    localparam logic [7:0] IDX_PHASE_LO   = 8'h37;
    localparam logic [7:0] IDX_PHASE_HI   = 8'h38;
    localparam logic [7:0] IDX_GAIN       = 8'h39;
    localparam logic [7:0] IDX_FILTER     = 8'h3B;
    localparam logic [7:0] IDX_CLAMP      = 8'h3D;
    localparam logic [7:0] IDX_AUX        = 8'h3E;
    localparam logic [7:0] IDX_STATUS     = 8'h3F;
    localparam int         NSLOT          = 16;
    localparam logic [3:0] SLOT_CLOCK     = 4'h0;
    localparam logic [3:0] SLOT_PHASE_LO  = 4'h1;
    localparam logic [3:0] SLOT_PHASE_HI  = 4'h2;
    localparam logic [3:0] SLOT_GAIN      = 4'h3;
    localparam logic [3:0] SLOT_FILTER    = 4'h5;
    localparam logic [3:0] SLOT_CLAMP     = 4'h7;
    localparam logic [3:0] SLOT_AUX       = 4'h8;
    localparam logic [3:0] SLOT_STATUS    = 4'h9;
    localparam logic [15:0] RESET_VALUE   = 16'h0000;
    // ------------------------------------------------------------
    // Writable bits per slot, zero for unmapped slots
    // ------------------------------------------------------------
    localparam logic [15:0] WMASK [NSLOT] = '{
        16'h0F7F, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h03FC, 16'h0000, 16'hE000,
        16'h000F, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CLK_TYPE_BIT  = 6;
    localparam int PATH_BIT      = 8;
    localparam int SUM_DIS_BIT   = 9;
    localparam int MULT_LSB      = 10;
    localparam int HPF_LSB       = 2;
    localparam int ATT_LSB       = 4;
    localparam int ATT_EN_BIT    = 7;
    localparam int SUM_PDN_BIT   = 8;
    localparam int TEST_BIT      = 9;
    localparam int V2I_BIT       = 13;
    localparam int LPF_BIT       = 14;
    localparam int FS_CLAMP_BIT  = 15;
    localparam int AUX_GAIN_EN   = 0;
    localparam int AUX_PDN_BIT   = 1;
    localparam int AUX_GAIN_LSB  = 2;
    localparam logic [1:0] GAIN_24DB   = 2'h1;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MULT_16X, MULT_8X, MULT_4X, MULT_1X} ctpc_mult_t;
    typedef enum logic {PATH_IMAGING, PATH_CW} ctpc_path_t;
    typedef struct packed {
        logic        single_rate_clock_input_type;
        ctpc_path_t  path_select;
        logic        summing_amplifier_on;
        ctpc_mult_t  clock_multiplier_mode;
        logic [31:0] channel_mixer_phase;
        logic [15:0] channel_input_gain;
        logic [1:0]  input_highpass_corner;
        logic        digital_atten_enable;
        logic [2:0]  digital_atten_step;
        logic        gain_stage_test_route;
        logic        converter_input_clamp;
        logic        narrow_lowpass_enable;
        logic [7:0]  minus6_fullscale_clamp;
        logic        atten_and_gain_powerdown;
    } ctpc_cfg_t;
endpackage : ctpc_pkg
`default_nettype wire

// [ctpc_regs.sv]
// Behaviour
// R1: bit 6 of clock/path register picks CMOS (0) or differential (1) clock.
// R2: bit 8 picks imaging (0) or CW (1); CW leaves gain stages powered.
// R3: bit 9 high disables summing amplifier, effective only in CW mode.
// R4: bits 11:10 pick 16x, 8x, 4x or 1x clock multiplier mode.
// R5: eight 4-bit mixer phase fields, channels 1-4 then 5-8, ascending.
// R6: 2-bit per-channel gain fields, channel 1 lowest; need individual enable.
// R7: filter register bits 3:2 pick the input high-pass corner.
// R8: attenuator applies N x 6 dB when enabled, otherwise disabled.
// R9: bit 8 powers summing amplifier down, only in imaging test mode.
// R10: bit 9 routes gain-stage outputs onto CW outputs.
// R11: clamp register bit 13 enables converter input clamp.
// R12: bit 14 enables narrow low-pass; software sets main filter field.
// R13: bit 15 enables minus 6 dBFS clamp, valid only at 24 dB gain.
// R14: individual gain enable low means common gain applies to all channels.
// R15: separate power-down bit shuts attenuator and gain stage.
// R16: software writes zero to all reserved bits.
// R17: registers 16 bits, reset to zero, hold last written value.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module ctpc_regs #(
    parameter int AW = 12
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // Write address
    input  wire logic [AW-1:0]         awaddr,
    input  wire logic [2:0]            awprot,
    input  wire logic                  awvalid,
    output logic                       awready,
    // Write data
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    // Write response
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // Read address
    input  wire logic [AW-1:0]         araddr,
    input  wire logic [2:0]            arprot,
    input  wire logic                  arvalid,
    output logic                       arready,
    // Read data
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Analog path controls
    output var ctpc_pkg::ctpc_cfg_t    cfg_q
);
    // ------------------------------------------------------------
    // Bus state
    // ------------------------------------------------------------
    logic [AW-1:0] awaddr_q;
    logic [15:0]   wdata_q;
    logic [1:0]    wstrb_q;
    logic          aw_full_q;
    logic          w_full_q;
    logic          awready_q;
    logic          wready_q;
    logic          bvalid_q;
    logic [1:0]    bresp_q;
    logic          arready_q;
    logic          rvalid_q;
    logic [31:0]   rdata_q;
    logic [1:0]    rresp_q;
    logic [15:0]   regs_q [ctpc_pkg::NSLOT];

    assign awready = awready_q;
    assign wready  = wready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;

    // ------------------------------------------------------------
    // Write channel handshakes
    // ------------------------------------------------------------
    wire aw_take   = awvalid & awready_q;
    wire w_take    = wvalid & wready_q;
    wire wr_fire   = aw_full_q & w_full_q & ~bvalid_q;
    wire aw_full_d = aw_take | (aw_full_q & ~wr_fire);
    wire w_full_d  = w_take | (w_full_q & ~wr_fire);
    wire bvalid_d  = wr_fire | (bvalid_q & ~bready);

    wire [AW-1:0] awaddr_d = aw_take ? awaddr : awaddr_q;
    wire [15:0]   wdata_d  = w_take ? wdata[15:0] : wdata_q;
    wire [1:0]    wstrb_d  = w_take ? wstrb[1:0] : wstrb_q;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [7:0] wr_idx  = awaddr_q[9:2];
    wire [7:0] wr_diff = wr_idx - ctpc_pkg::IDX_BASE;
    wire [3:0] wr_slot = wr_diff[3:0];
    wire       wr_in   = (awaddr_q[AW-1:10] == '0) && (wr_idx >= ctpc_pkg::IDX_BASE)
                         && (wr_diff < 8'h10);
    wire       wr_map  = wr_in && (ctpc_pkg::WMASK[wr_slot] != 16'h0000);
    wire [15:0] wr_bm  = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & ctpc_pkg::WMASK[wr_slot];
    wire [1:0] bresp_d = wr_fire ? (wr_map ? ctpc_pkg::RESP_OKAY : ctpc_pkg::RESP_SLVERR)
                                 : bresp_q;

    wire [7:0] rd_idx  = araddr[9:2];
    wire [7:0] rd_diff = rd_idx - ctpc_pkg::IDX_BASE;
    wire [3:0] rd_slot = rd_diff[3:0];
    wire       rd_in   = (araddr[AW-1:10] == '0) && (rd_idx >= ctpc_pkg::IDX_BASE)
                         && (rd_diff < 8'h10);
    wire       rd_stat = rd_in && (rd_slot == ctpc_pkg::SLOT_STATUS);
    wire       rd_map  = rd_stat || (rd_in && (ctpc_pkg::WMASK[rd_slot] != 16'h0000));

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    wire        ar_take  = arvalid & arready_q;
    wire        rvalid_d = ar_take | (rvalid_q & ~rready);
    wire [15:0] stat_val = {10'h000, cfg_q.atten_and_gain_powerdown,
                            cfg_q.digital_atten_step, cfg_q.summing_amplifier_on,
                            cfg_q.path_select == ctpc_pkg::PATH_CW};
    wire [15:0] rd_val   = !rd_map ? 16'h0000 : (rd_stat ? stat_val : regs_q[rd_slot]);
    wire [31:0] rdata_d  = ar_take ? {16'h0000, rd_val} : rdata_q;
    wire [1:0]  rresp_d  = ar_take ? (rd_map ? ctpc_pkg::RESP_OKAY : ctpc_pkg::RESP_SLVERR)
                                   : rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= ctpc_pkg::RESP_OKAY;
            awaddr_q  <= '0;
            wdata_q   <= 16'h0000;
            wstrb_q   <= 2'h0;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h00000000;
            rresp_q   <= ctpc_pkg::RESP_OKAY;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q  <= w_full_d;
            awready_q <= ~aw_full_d;
            wready_q  <= ~w_full_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    for (genvar i = 0; i < ctpc_pkg::NSLOT; i++) begin : g_reg
        wire        hit   = wr_fire && wr_map && (wr_slot == 4'(i));
        wire [15:0] value = hit ? ((regs_q[i] & ~wr_bm) | (wdata_q & wr_bm)) : regs_q[i];
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                regs_q[i] <= ctpc_pkg::RESET_VALUE; // R17
            end else begin
                regs_q[i] <= value; // R17 R16
            end
        end
    end

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    wire [15:0] r_clk  = regs_q[ctpc_pkg::SLOT_CLOCK];
    wire [15:0] r_plo  = regs_q[ctpc_pkg::SLOT_PHASE_LO];
    wire [15:0] r_phi  = regs_q[ctpc_pkg::SLOT_PHASE_HI];
    wire [15:0] r_gain = regs_q[ctpc_pkg::SLOT_GAIN];
    wire [15:0] r_filt = regs_q[ctpc_pkg::SLOT_FILTER];
    wire [15:0] r_clmp = regs_q[ctpc_pkg::SLOT_CLAMP];
    wire [15:0] r_aux  = regs_q[ctpc_pkg::SLOT_AUX];

    wire       is_cw    = r_clk[ctpc_pkg::PATH_BIT];
    wire       test_rt  = r_filt[ctpc_pkg::TEST_BIT];
    wire       sum_on   = is_cw ? ~r_clk[ctpc_pkg::SUM_DIS_BIT] // R3
                                : (test_rt & ~r_filt[ctpc_pkg::SUM_PDN_BIT]); // R9
    wire       gain_en  = r_aux[ctpc_pkg::AUX_GAIN_EN];
    wire [1:0] gain_com = r_aux[ctpc_pkg::AUX_GAIN_LSB +: 2];
    wire       att_en   = r_filt[ctpc_pkg::ATT_EN_BIT];
    wire [2:0] att_step = att_en ? r_filt[ctpc_pkg::ATT_LSB +: 3] : 3'h0; // R8
    wire       fs_clamp = r_clmp[ctpc_pkg::FS_CLAMP_BIT];
    wire [15:0] gain_d;
    wire [7:0]  clamp_d;

    for (genvar c = 0; c < 8; c++) begin : g_ch
        assign gain_d[2*c +: 2] = gain_en ? r_gain[2*c +: 2] : gain_com; // R6 R14
        assign clamp_d[c] = fs_clamp && (gain_d[2*c +: 2] == ctpc_pkg::GAIN_24DB); // R13
    end

    ctpc_pkg::ctpc_cfg_t cfg_d;
    always_comb begin
        cfg_d = '0;
        cfg_d.single_rate_clock_input_type = r_clk[ctpc_pkg::CLK_TYPE_BIT]; // R1
        cfg_d.path_select = is_cw ? ctpc_pkg::PATH_CW : ctpc_pkg::PATH_IMAGING; // R2
        cfg_d.summing_amplifier_on = sum_on; // R3 R9
        cfg_d.clock_multiplier_mode = ctpc_pkg::ctpc_mult_t'(r_clk[ctpc_pkg::MULT_LSB +: 2]); // R4
        cfg_d.channel_mixer_phase = {r_phi, r_plo}; // R5
        cfg_d.channel_input_gain = gain_d; // R6 R14
        cfg_d.input_highpass_corner = r_filt[ctpc_pkg::HPF_LSB +: 2]; // R7
        cfg_d.digital_atten_enable = att_en; // R8
        cfg_d.digital_atten_step = att_step; // R8
        cfg_d.gain_stage_test_route = test_rt; // R10
        cfg_d.converter_input_clamp = r_clmp[ctpc_pkg::V2I_BIT]; // R11
        cfg_d.narrow_lowpass_enable = r_clmp[ctpc_pkg::LPF_BIT]; // R12
        cfg_d.minus6_fullscale_clamp = clamp_d; // R13
        cfg_d.atten_and_gain_powerdown = r_aux[ctpc_pkg::AUX_PDN_BIT]; // R15 R2
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_clk_type;
        wr_fire && wr_map && (wr_slot == ctpc_pkg::SLOT_CLOCK) && wstrb_q[0]
        |=> ##1 cfg_q.single_rate_clock_input_type == $past(wdata_q[6], 2);
    endproperty
    a_clk_type: assert property (p_clk_type) else $error("clock type not applied"); // R1

    property p_path_keeps_power;
        $changed(cfg_q.path_select) |-> $stable(cfg_q.atten_and_gain_powerdown);
    endproperty
    a_path_keeps_power: assert property (p_path_keeps_power) else $error("path changed power"); // R2

    property p_sum_cw;
        $past(is_cw) |-> cfg_q.summing_amplifier_on == !$past(r_clk[9]);
    endproperty
    a_sum_cw: assert property (p_sum_cw) else $error("summing enable wrong in CW"); // R3

    property p_sum_imaging;
        $past(!is_cw && !test_rt) |-> !cfg_q.summing_amplifier_on;
    endproperty
    a_sum_imaging: assert property (p_sum_imaging) else $error("summing on outside test mode"); // R9

    property p_mult;
        cfg_q.clock_multiplier_mode == $past(r_clk[11:10]);
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier mode mismatch"); // R4

    property p_phase5;
        cfg_q.channel_mixer_phase[19:16] == $past(r_phi[3:0]);
    endproperty
    a_phase5: assert property (p_phase5) else $error("channel 5 phase mismatch"); // R5

    property p_common_gain;
        $past(!gain_en) |-> cfg_q.channel_input_gain == {8{$past(gain_com)}};
    endproperty
    a_common_gain: assert property (p_common_gain) else $error("common gain not applied"); // R14

    property p_att_off;
        $past(!att_en) |-> cfg_q.digital_atten_step == 3'h0;
    endproperty
    a_att_off: assert property (p_att_off) else $error("attenuation while disabled"); // R8

    property p_clamp_24;
        cfg_q.minus6_fullscale_clamp[7] |-> cfg_q.channel_input_gain[15:14] == 2'h1;
    endproperty
    a_clamp_24: assert property (p_clamp_24) else $error("clamp at wrong gain"); // R13

    property p_test_route;
        cfg_q.gain_stage_test_route == $past(r_filt[ctpc_pkg::TEST_BIT]);
    endproperty
    a_test_route: assert property (p_test_route) else $error("test routing mismatch"); // R10

    property p_input_clamp;
        cfg_q.converter_input_clamp == $past(r_clmp[ctpc_pkg::V2I_BIT]);
    endproperty
    a_input_clamp: assert property (p_input_clamp) else $error("input clamp mismatch"); // R11

    property p_narrow_lpf;
        cfg_q.narrow_lowpass_enable == $past(r_clmp[ctpc_pkg::LPF_BIT]);
    endproperty
    a_narrow_lpf: assert property (p_narrow_lpf) else $error("low-pass mismatch"); // R12

    property p_hold;
        !(wr_fire && wr_slot == ctpc_pkg::SLOT_CLAMP) |=> $stable(r_clmp);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write"); // R17

    property p_bresp;
        wr_fire |=> bvalid_q ##0 (bresp_q == ($past(wr_map) ? 2'h0 : 2'h2));
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response missing");
endmodule : ctpc_regs
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin checks++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module testbench;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic                aclk    = 1'b0;
    logic                aresetn = 1'b0;
    logic [11:0]         awaddr  = '0;
    logic [11:0]         araddr  = '0;
    logic [31:0]         wdata   = '0;
    logic [3:0]          wstrb   = '0;
    logic                awvalid = 1'b0;
    logic                wvalid  = 1'b0;
    logic                bready  = 1'b0;
    logic                arvalid = 1'b0;
    logic                rready  = 1'b0;
    logic                awready, wready, bvalid, arready, rvalid;
    logic [1:0]          bresp, rresp;
    logic [31:0]         rdata;
    ctpc_pkg::ctpc_cfg_t cfg_q;
    logic [15:0]         sh [16];
    logic [1:0]          bq [$];
    logic [33:0]         rq [$];
    logic [1:0]          eb;
    logic [33:0]         er;
    int                  fails  = 0;
    int                  checks = 0;

    always #25 aclk = ~aclk;

    ctpc_regs u_ctpc_regs (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cfg_q(cfg_q)
    );

    // ------------------------------------------------------------
    // Expected values
    // ------------------------------------------------------------
    function automatic logic mapped(input logic [7:0] idx);
        return idx >= 8'h36 && idx <= 8'h3F && idx != 8'h3A && idx != 8'h3C;
    endfunction : mapped

    function automatic ctpc_pkg::ctpc_cfg_t exp_cfg();
        ctpc_pkg::ctpc_cfg_t e;
        logic [15:0]         g;
        e = '0;
        g = sh[8][0] ? sh[3] : {8{sh[8][3:2]}};
        e.single_rate_clock_input_type = sh[0][6];
        e.path_select = ctpc_pkg::ctpc_path_t'(sh[0][8]);
        e.summing_amplifier_on = sh[0][8] ? !sh[0][9] : (sh[5][9] && !sh[5][8]);
        e.clock_multiplier_mode = ctpc_pkg::ctpc_mult_t'(sh[0][11:10]);
        e.channel_mixer_phase = {sh[2], sh[1]};
        e.channel_input_gain = g;
        e.input_highpass_corner = sh[5][3:2];
        e.digital_atten_enable = sh[5][7];
        e.digital_atten_step = sh[5][7] ? sh[5][6:4] : 3'h0;
        e.gain_stage_test_route = sh[5][9];
        e.converter_input_clamp = sh[7][13];
        e.narrow_lowpass_enable = sh[7][14];
        for (int c = 0; c < 8; c++)
            e.minus6_fullscale_clamp[c] = sh[7][15] && g[2*c +: 2] == ctpc_pkg::GAIN_24DB;
        e.atten_and_gain_powerdown = sh[8][1];
        return e;
    endfunction : exp_cfg

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] s);
        logic        aw_ok;
        logic        w_ok;
        logic [3:0]  sl;
        logic [15:0] m;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        sl = 4'(idx - ctpc_pkg::IDX_BASE);
        m  = ctpc_pkg::WMASK[sl] & {{8{s[1]}}, {8{s[0]}}};
        if (mapped(idx) && idx != ctpc_pkg::IDX_STATUS) begin
            sh[sl] = (sh[sl] & ~m) | (d & m);
            bq.push_back(ctpc_pkg::RESP_OKAY);
        end else begin
            bq.push_back(ctpc_pkg::RESP_SLVERR);
        end
        @(posedge aclk);
        awaddr  <= {2'h0, idx, 2'h0};
        wdata   <= {16'($urandom), d};
        wstrb   <= {2'($urandom), s};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] idx);
        ctpc_pkg::ctpc_cfg_t e;
        e = exp_cfg();
        if (idx == ctpc_pkg::IDX_STATUS)
            rq.push_back({ctpc_pkg::RESP_OKAY, 16'h0000, 10'h000, e.atten_and_gain_powerdown,
                          e.digital_atten_step, e.summing_amplifier_on,
                          (e.path_select == ctpc_pkg::PATH_CW)});
        else if (mapped(idx)) rq.push_back({ctpc_pkg::RESP_OKAY, 16'h0000, sh[4'(idx - 8'h36)]});
        else rq.push_back({ctpc_pkg::RESP_SLVERR, 32'h0000_0000});
        @(posedge aclk);
        araddr  <= {2'h0, idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd

    task automatic chk_cfg();
        repeat (3) @(posedge aclk);
        #1;
        `CHK("cfg_q", cfg_q, exp_cfg())
    endtask : chk_cfg

    task automatic end_sim();
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // Response monitor
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready) begin
            eb = bq.pop_front();
            `CHK("bresp", bresp, eb)
        end
        if (rvalid === 1'b1 && rready) begin
            er = rq.pop_front();
            `CHK("read", {rresp, rdata}, er)
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(2896));
        foreach (sh[i]) sh[i] = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        `CHK("cfg_q", cfg_q, exp_cfg())
        for (int i = 8'h35; i <= 8'h40; i++) rd(8'(i));
        wr(8'h3A, 16'hFFFF, 2'h3);
        wr(ctpc_pkg::IDX_STATUS, 16'hFFFF, 2'h3);
        for (int i = 0; i < 16; i++) begin
            wr(ctpc_pkg::IDX_CLOCK_PATH, {4'h0, 4'(i), 1'b0, 7'($urandom)}, 2'h3);
            chk_cfg();
            rd(ctpc_pkg::IDX_CLOCK_PATH);
        end
        wr(ctpc_pkg::IDX_PHASE_LO, 16'($urandom), 2'h3);
        wr(ctpc_pkg::IDX_PHASE_HI, 16'($urandom), 2'h3);
        wr(ctpc_pkg::IDX_PHASE_LO, 16'($urandom), 2'h1);
        wr(ctpc_pkg::IDX_PHASE_HI, 16'($urandom), 2'h2);
        chk_cfg();
        rd(ctpc_pkg::IDX_PHASE_LO);
        for (int i = 0; i < 12; i++) begin
            wr(ctpc_pkg::IDX_AUX, {12'($urandom), 4'(i)}, 2'h3);
            wr(ctpc_pkg::IDX_GAIN, i[0] ? 16'h5555 : 16'($urandom), 2'h3);
            wr(ctpc_pkg::IDX_CLAMP, {3'($urandom), 13'h0000}, 2'h3);
            chk_cfg();
            rd(ctpc_pkg::IDX_CLAMP);
        end
        for (int p = 0; p < 2; p++) begin
            wr(ctpc_pkg::IDX_CLOCK_PATH, 16'(p << 8), 2'h3);
            for (int i = 0; i < 8; i++) begin
                wr(ctpc_pkg::IDX_FILTER, {6'h00, 3'(i), 5'($urandom), 2'h0}, 2'h3);
                chk_cfg();
                rd(ctpc_pkg::IDX_FILTER);
                rd(ctpc_pkg::IDX_STATUS);
            end
        end
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (sh[i]) sh[i] = '0;
        @(posedge aclk);
        #1;
        `CHK("cfg_q", cfg_q, exp_cfg())
        rd(ctpc_pkg::IDX_GAIN);
        end_sim();
    end

    initial begin
        #500_000;
        fails++;
        end_sim();
    end
endmodule : testbench
`default_nettype wire
